/* design/fsrs_core.sv */
/*
 * Serial flash command interpreter: erase-suspend programming, resume,
 * two-step software reset, parameter table read, APB status/control.
 * Assumes a mode-0 serial host with SCLK far slower than CLK_SYS (>= 8x).
 */
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module fsrs_core import fsrs_pkg::*; #(
	parameter logic [CNT_W-1:0] PROG_CYC      = PROG_CYC_DEF,
	parameter logic [CNT_W-1:0] ERASE_CYC     = ERASE_CYC_DEF,
	parameter logic [CNT_W-1:0] RCV_PGM_CYC   = RCV_PGM_CYC_DEF,
	parameter logic [CNT_W-1:0] RCV_OTHER_CYC = RCV_OTHER_CYC_DEF,
	parameter logic [7:0]       MFR_ID        = 8'hA5 // value arbitrary
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        SCLK,
	input  wire logic        CS_N,
	input  wire logic        SI,
	output logic             SO,
	output logic             SO_OE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	logic                  sclk_s1, sclk_s2, sclk_s3;
	logic                  cs_n_s1, cs_n_s2, cs_n_s3;
	logic                  si_s1, si_s2;
	logic                  sclk_rise, sclk_fall, cs_on, cs_rise;
	logic [2:0]            bit_cnt, byte_cnt, obit;
	logic [7:0]            shreg, opcode, next_byte, out_sh, tab_byte;
	logic [23:0]           ptr;
	logic                  data_phase, first_load, next_load, byte_end;
	fsrs_op_e              op;
	logic [CNT_W-1:0]      op_cnt, sus_rem;
	logic                  write_enable_latch, write_in_progress, program_suspended_flag, erase_suspended_flag, arm, xip, pp_in_susp;
	logic [23-SECTOR_LSB:0] sus_sector;
	logic                  cmd_end, cmd_ok, one_byte, running, op_done;
	logic                  rst_ok, resume_ok, pp_ok, se_ok, susp_req, susp_ok;
	logic                  apb_wr, mapped;
	logic [31:0]           rd_word;

	// two-stage synchronisers; stage 3 only feeds edge detection
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			cs_n_s3 <= 1'b1;
			si_s1   <= 1'b0;
			si_s2   <= 1'b0;
		end else begin
			sclk_s1 <= SCLK;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_n_s1 <= CS_N;
			cs_n_s2 <= cs_n_s1;
			cs_n_s3 <= cs_n_s2;
			si_s1   <= SI;
			si_s2   <= si_s1;
		end
	end

	assign sclk_rise  = sclk_s2 & ~sclk_s3;
	assign sclk_fall  = ~sclk_s2 & sclk_s3;
	assign cs_on      = ~cs_n_s2;
	assign cs_rise    = cs_n_s2 & ~cs_n_s3;
	assign next_byte  = {shreg[6:0], si_s2};
	assign byte_end   = cs_on & sclk_rise & (bit_cnt == 3'h7);
	assign first_load = byte_end & (byte_cnt == BYTE_DUMMY) & (opcode == OPC_READ_PARAM);
	assign next_load  = data_phase & sclk_fall & (obit == 3'h7);

	// input shifter, msb first on rising serial clock
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			shreg    <= 8'h00;
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			opcode   <= 8'h00;
		end else if (!cs_on) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (sclk_rise) begin
			shreg   <= next_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				if (byte_cnt != BYTE_SAT)
					byte_cnt <= byte_cnt + 3'h1;
				if (byte_cnt == 3'h0)
					opcode <= next_byte;
			end
		end
	end

	// address bytes, then post-increment while the table streams out
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ptr <= 24'h00_0000;
		end else if (byte_end && byte_cnt != 3'h0 && byte_cnt <= BYTE_ADDR_LAST) begin
			ptr <= {ptr[15:0], next_byte};
		end else if (first_load || next_load) begin
			ptr <= ptr + 24'h00_0001;
		end
	end

	fsrs_ptab #(
		.MFR_ID (MFR_ID)
	) u_ptab (
		.addr (ptr),
		.data (tab_byte)
	);

	// output drives on falling serial clock so the host samples on rising
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			data_phase <= 1'b0;
			out_sh     <= 8'h00;
			obit       <= 3'h0;
			SO         <= 1'b0;
			SO_OE      <= 1'b0;
		end else if (!cs_on) begin
			data_phase <= 1'b0;
			obit       <= 3'h0;
			SO_OE      <= 1'b0;
		end else if (first_load) begin
			data_phase <= 1'b1;
			out_sh     <= tab_byte;
			obit       <= 3'h0;
		end else if (data_phase && sclk_fall) begin
			SO    <= out_sh[7];
			SO_OE <= 1'b1;
			obit  <= obit + 3'h1;
			out_sh <= (obit == 3'h7) ? tab_byte : {out_sh[6:0], 1'b0};
		end
	end

	// command decode at the closing chip-select edge; partial bytes discard
	assign cmd_end   = cs_rise & (bit_cnt == 3'h0) & (byte_cnt != 3'h0);
	assign cmd_ok    = cmd_end & (op != OP_RECOVER);
	assign one_byte  = byte_cnt == 3'h1;
	assign running   = (op == OP_PROGRAM) | (op == OP_ERASE);
	assign op_done   = (op != OP_IDLE) & (op_cnt == 24'h00_0001);
	assign rst_ok    = cmd_ok & one_byte & (opcode == OPC_RESET_EXEC) & arm;
	assign resume_ok = cmd_ok & one_byte & (opcode == OPC_RESUME || opcode == OPC_RESUME_ALT)
		& ~xip & (op == OP_IDLE) & (program_suspended_flag | erase_suspended_flag);
	assign pp_ok     = cmd_ok & (opcode == OPC_PAGE_PROG) & (byte_cnt >= BYTE_PP_MIN) & write_enable_latch
		& (op == OP_IDLE) & ~program_suspended_flag & (~erase_suspended_flag | (ptr[23:SECTOR_LSB] != sus_sector));
	assign se_ok     = cmd_ok & (opcode == OPC_SECTOR_ERASE) & (byte_cnt == BYTE_DUMMY)
		& write_enable_latch & (op == OP_IDLE) & ~program_suspended_flag & ~erase_suspended_flag;
	assign apb_wr    = PSEL & PENABLE & PWRITE;
	assign susp_req  = apb_wr & (PADDR == REG_CTRL) & PWDATA[CTRL_SUSPEND];
	// a program begun inside an erase suspend cannot itself be suspended
	assign susp_ok   = susp_req & running & ~pp_in_susp & ~op_done;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			op         <= OP_IDLE;
			op_cnt     <= 24'h00_0000;
			sus_rem    <= 24'h00_0000;
			sus_sector <= '0;
			write_enable_latch        <= 1'b0;
			write_in_progress        <= 1'b0;
			program_suspended_flag        <= 1'b0;
			erase_suspended_flag        <= 1'b0;
			arm        <= 1'b0;
			xip        <= 1'b0;
			pp_in_susp <= 1'b0;
		end else if (rst_ok) begin
			// abort whatever runs; array contents may be left damaged
			op         <= OP_RECOVER;
			op_cnt     <= (op == OP_PROGRAM) ? RCV_PGM_CYC : RCV_OTHER_CYC;
			sus_rem    <= 24'h00_0000;
			write_enable_latch        <= 1'b0;
			write_in_progress        <= 1'b0;
			program_suspended_flag        <= 1'b0;
			erase_suspended_flag        <= 1'b0;
			arm        <= 1'b0;
			xip        <= 1'b0;
			pp_in_susp <= 1'b0;
		end else begin
			if (op_done) begin
				op <= OP_IDLE;
				if (op != OP_RECOVER) begin
					write_enable_latch        <= 1'b0;
					write_in_progress        <= 1'b0;
					pp_in_susp <= 1'b0;
				end
			end else if (op != OP_IDLE) begin
				op_cnt <= op_cnt - 24'h00_0001;
			end
			if (susp_ok) begin
				op      <= OP_IDLE;
				sus_rem <= op_cnt;
				write_enable_latch     <= 1'b0;
				write_in_progress     <= 1'b0;
				program_suspended_flag     <= op == OP_PROGRAM;
				erase_suspended_flag     <= op == OP_ERASE;
			end
			if (cmd_ok)
				arm <= one_byte & (opcode == OPC_RESET_ARM);
			if (cmd_ok && one_byte && opcode == OPC_WRITE_ENABLE && !program_suspended_flag)
				write_enable_latch <= 1'b1;
			if (pp_ok) begin
				op         <= OP_PROGRAM;
				op_cnt     <= PROG_CYC;
				write_in_progress        <= 1'b1;
				pp_in_susp <= erase_suspended_flag;
			end
			if (se_ok) begin
				op         <= OP_ERASE;
				op_cnt     <= ERASE_CYC;
				write_in_progress        <= 1'b1;
				sus_sector <= ptr[23:SECTOR_LSB];
			end
			if (resume_ok) begin
				op     <= program_suspended_flag ? OP_PROGRAM : OP_ERASE;
				op_cnt <= sus_rem;
				write_enable_latch    <= 1'b1;
				write_in_progress    <= 1'b1;
				program_suspended_flag    <= 1'b0;
				erase_suspended_flag    <= 1'b0;
			end
			if (apb_wr && PADDR == REG_CTRL)
				xip <= PWDATA[CTRL_XIP];
		end
	end

	// zero-wait APB slave; read word latched in the setup cycle
	assign PREADY  = 1'b1;
	assign mapped  = (PADDR == REG_CTRL) | (PADDR == REG_STATUS) | (PADDR == REG_SECURITY);
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (PADDR == REG_CTRL) begin
			rd_word[CTRL_XIP] = xip;
		end else if (PADDR == REG_STATUS) begin
			rd_word[ST_WIP]     = write_in_progress;
			rd_word[ST_WEL]     = write_enable_latch;
			rd_word[ST_ARM]     = arm;
			rd_word[ST_RECOVER] = op == OP_RECOVER;
		end else if (PADDR == REG_SECURITY) begin
			rd_word[SEC_PSB] = program_suspended_flag;
			rd_word[SEC_ESB] = erase_suspended_flag;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE)
			PRDATA <= rd_word;
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence s_dummy_done;
		byte_end && byte_cnt == BYTE_DUMMY && opcode == OPC_READ_PARAM;
	endsequence

	sequence s_first_bit;
		data_phase && sclk_fall ##1 SO_OE;
	endsequence

	a_prog_holds_bits: assert property ((op == OP_PROGRAM) |-> write_enable_latch && write_in_progress)
		else $error("program running without latch and busy set");
	a_prog_end_clears: assert property (op == OP_PROGRAM && op_done |=> !write_enable_latch && !write_in_progress)
		else $error("latch or busy left set after program");
	a_susp_sector: assert property (cmd_ok && opcode == OPC_PAGE_PROG && erase_suspended_flag
		&& op == OP_IDLE && ptr[23:SECTOR_LSB] == sus_sector |=> op != OP_PROGRAM)
		else $error("program started inside suspended erase sector");
	a_resume_bits: assert property (resume_ok |=> write_enable_latch && write_in_progress && !program_suspended_flag && !erase_suspended_flag
		&& op != OP_IDLE && op_cnt == $past(sus_rem))
		else $error("resume did not restore operation state");
	a_xip_no_resume: assert property (cmd_ok && xip && op == OP_IDLE
		&& (opcode == OPC_RESUME || opcode == OPC_RESUME_ALT) |=> $stable(program_suspended_flag) && $stable(erase_suspended_flag))
		else $error("resume acted in execute-in-place mode");
	a_noop_only_arm: assert property (cmd_ok && opcode == OPC_NO_OP
		&& !op_done && !susp_ok
		|=> !arm && $stable(program_suspended_flag) && $stable(erase_suspended_flag) && $stable(write_enable_latch) && $stable(write_in_progress))
		else $error("no-op changed more than the reset arm");
	a_reset_needs_arm: assert property (cmd_ok && opcode == OPC_RESET_EXEC && !arm
		&& op != OP_RECOVER |=> op != OP_RECOVER)
		else $error("reset executed without a preceding arm");
	a_reset_aborts: assert property (rst_ok |=> op == OP_RECOVER && !write_enable_latch && !write_in_progress
		&& !program_suspended_flag && !erase_suspended_flag && !xip && !arm ##[1:300] op == OP_IDLE)
		else $error("reset did not abort and recover to standby");
	a_recover_length: assert property (rst_ok && op == OP_PROGRAM
		|=> op_cnt == RCV_PGM_CYC && RCV_PGM_CYC > RCV_OTHER_CYC)
		else $error("recovery after program not the longer time");
	a_susp_flag: assert property (susp_ok && op == OP_PROGRAM |=> program_suspended_flag && !erase_suspended_flag && !write_in_progress)
		else $error("program suspend flag not set");
	a_table_start: assert property (s_dummy_done |=> data_phase && ptr == $past(ptr) + 24'h00_0001)
		else $error("table data phase did not start after dummy byte");
	a_table_step: assert property (next_load |=> ptr == $past(ptr) + 24'h00_0001
		&& out_sh == $past(tab_byte))
		else $error("table address did not advance per byte");
	a_first_bit: assert property (s_first_bit |-> SO == $past(out_sh[7]))
		else $error("first table bit not driven from the loaded byte");
endmodule : fsrs_core
`default_nettype wire

/* design/fsrs_pkg.sv */
/*
 * Shared constants for the flash command interpreter: opcodes, register map,
 * field positions, operation states and default operation lengths.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package fsrs_pkg;
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_PAGE_PROG    = 8'h02;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OPC_RESUME       = 8'h7A;
	localparam logic [7:0] OPC_RESUME_ALT   = 8'h30;
	localparam logic [7:0] OPC_RESET_ARM    = 8'h66;
	localparam logic [7:0] OPC_RESET_EXEC   = 8'h99;
	localparam logic [7:0] OPC_NO_OP        = 8'h00;
	localparam logic [7:0] OPC_READ_PARAM   = 8'h5A;

	// byte positions inside a frame, opcode is byte 0
	localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
	localparam logic [2:0] BYTE_DUMMY     = 3'h4;
	localparam logic [2:0] BYTE_PP_MIN    = 3'h5;
	localparam logic [2:0] BYTE_SAT       = 3'h7;

	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_SECURITY = 8'h08;

	localparam int CTRL_XIP     = 0;
	localparam int CTRL_SUSPEND = 1;
	localparam int ST_WIP       = 0;
	localparam int ST_WEL       = 1;
	localparam int ST_ARM       = 4;
	localparam int ST_RECOVER   = 5;
	localparam int SEC_PSB      = 2;
	localparam int SEC_ESB      = 3;

	localparam int SECTOR_LSB = 12;
	localparam int CNT_W      = 24;

	localparam logic [CNT_W-1:0] PROG_CYC_DEF      = 24'h00_0100;
	localparam logic [CNT_W-1:0] ERASE_CYC_DEF     = 24'h00_0400;
	localparam logic [CNT_W-1:0] RCV_PGM_CYC_DEF   = 24'h00_0040;
	localparam logic [CNT_W-1:0] RCV_OTHER_CYC_DEF = 24'h00_0010;

	typedef enum logic [1:0] {
		OP_IDLE    = 2'b00,
		OP_PROGRAM = 2'b01,
		OP_ERASE   = 2'b10,
		OP_RECOVER = 2'b11
	} fsrs_op_e;
endpackage : fsrs_pkg
`default_nettype wire

/* design/fsrs_ptab.sv */
/*
 * Discoverable parameter header lookup, one byte per address.
 * Assumes the caller registers the byte; locations past the headers read FFh.
 */
`timescale 1ns/100ps
`default_nettype none
module fsrs_ptab #(
	parameter logic [7:0] MFR_ID = 8'hA5 // value arbitrary
) (
	input  wire logic [23:0] addr,
	output logic      [7:0]  data
);
	always_comb begin
		data = 8'hFF;
		if (addr[23:5] == 19'h0_0000) begin
			unique case (addr[4:0])
				5'h00: data = 8'h53;
				5'h01: data = 8'h46;
				5'h02: data = 8'h44;
				5'h03: data = 8'h50;
				5'h04: data = 8'h00;
				5'h05: data = 8'h01;
				5'h06: data = 8'h01;
				5'h08: data = 8'h00;
				5'h09: data = 8'h00;
				5'h0A: data = 8'h01;
				5'h0B: data = 8'h09;
				5'h0C: data = 8'h30;
				5'h0D: data = 8'h00;
				5'h0E: data = 8'h00;
				5'h10: data = MFR_ID;
				5'h11: data = 8'h00;
				5'h12: data = 8'h01;
				5'h13: data = 8'h04;
				5'h14: data = 8'h60;
				5'h15: data = 8'h00;
				5'h16: data = 8'h00;
				default: data = 8'hFF;
			endcase
		end
	end
endmodule : fsrs_ptab
`default_nettype wire

/* dv/fsrs_host.sv */
/*
 * Serial host model: frames commands on SCLK, CS_N and SI, clocks bytes back from SO.
 * Assumes CLK_SYS at 125 MHz; SCLK is CLK_SYS/8, mode 0, still outside frames.
 */
`timescale 1ns/100ps
`default_nettype none
module fsrs_host (
	input  wire logic CLK_SYS,
	output logic      SCLK,
	output logic      CS_N,
	output logic      SI,
	input  wire logic SO
);
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SI   = 1'b0;
	end

	task automatic half;
		repeat (4) @(posedge CLK_SYS);
	endtask : half

	task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		CS_N <= 1'b0;
		foreach (tx[i]) begin
			for (int k = 7; k >= 0; k--) begin
				SI <= tx[i][k];
				half();
				SCLK <= 1'b1;
				half();
				SCLK <= 1'b0;
			end
		end
		for (int n = 0; n < nrd; n++) begin
			for (int k = 7; k >= 0; k--) begin
				half();
				SCLK <= 1'b1;
				b[k] = SO;
				half();
				SCLK <= 1'b0;
			end
			rx.push_back(b);
		end
		half();
		CS_N <= 1'b1;
		// released line must not keep its last level
		SI <= ~SI;
		repeat (8) @(posedge CLK_SYS);
	endtask : frame
endmodule : fsrs_host
`default_nettype wire

/* dv/fsrs_core_tb.sv */
/*
 * Self-checking bench for the flash command interpreter: APB tasks and a serial host.
 * Assumes the core answers APB with no wait and acts on commands at CS_N rise.
 */
`timescale 1ns/100ps
`default_nettype none
module fsrs_core_tb import fsrs_pkg::*;;
	localparam logic [7:0] MFR = 8'h3C; // value arbitrary
	localparam int PROGRAM_RESUME_TO_SUSPEND_GAP = 32; // cycles, host-side margin
	localparam logic [7:0] TAB [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
		8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MFR, 8'h00, 8'h01,
		8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};
	logic        clk;
	logic        rst;
	logic        sclk;
	logic        cs_n;
	logic        si;
	logic        so;
	logic        so_oe;
	logic        so_line;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  rx[$];
	int          errors;
	int          num_checks;
	int          n_pgm;
	int          n_oth;

	fsrs_core #(.PROG_CYC(24'h00_0400), .MFR_ID(MFR)) i_fsrs_core (
		.CLK_SYS(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so),
		.SO_OE(so_oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	fsrs_host i_fsrs_host (.CLK_SYS(clk), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so_line));
	// undriven line shows the inverse, so a sample taken before the enable is caught
	assign so_line = so_oe ? so : ~so;

	always #4 clk = ~clk;

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task automatic c1(input logic [7:0] op);
		i_fsrs_host.frame('{op}, 0, rx);
	endtask : c1

	task automatic pgm(input logic [23:0] a);
		i_fsrs_host.frame('{OPC_PAGE_PROG, a[23:16], a[15:8], a[7:0], 8'hA5}, 0, rx);
	endtask : pgm

	task automatic wait_idle;
		for (int i = 0; i < 1000; i++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rd[ST_WIP] === 1'b0 && rd[ST_RECOVER] === 1'b0) break;
		end
		if (rd[ST_WIP] !== 1'b0 || rd[ST_RECOVER] !== 1'b0) errors++;
	endtask : wait_idle

	task automatic rcv_len(output int n);
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[ST_RECOVER] === 1'b1 && n < 100);
		if (rd[ST_RECOVER] !== 1'b0) errors++;
	endtask : rcv_len

	task automatic suspend;
		apb(1'b1, REG_CTRL, 32'h2);
		repeat (8) @(posedge clk);
	endtask : suspend

	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		final_report();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		rdchk(REG_STATUS, 32'h0);
		rdchk(REG_SECURITY, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk({31'h0, err}, 32'h1);
		i_fsrs_host.frame('{OPC_READ_PARAM, 8'h00, 8'h00, 8'h00, 8'h00}, 24, rx);
		foreach (TAB[i]) chk({24'h0, rx[i]}, {24'h0, TAB[i]});
		chk({31'h0, so_oe}, 32'h0);
		pgm(24'h00_2000);
		rdchk(REG_STATUS, 32'h0);
		c1(OPC_WRITE_ENABLE);
		pgm(24'h00_2000);
		rdchk(REG_STATUS, 32'h3);
		wait_idle();
		rdchk(REG_STATUS, 32'h0);
		c1(OPC_WRITE_ENABLE);
		i_fsrs_host.frame('{OPC_SECTOR_ERASE, 8'h00, 8'h10, 8'h00}, 0, rx);
		suspend();
		rdchk(REG_SECURITY, 32'h8);
		c1(OPC_WRITE_ENABLE);
		pgm(24'h00_1004);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rd[ST_WIP]}, 32'h0);
		c1(OPC_WRITE_ENABLE);
		pgm(24'h00_5000);
		rdchk(REG_STATUS, 32'h3);
		c1(OPC_RESUME);
		suspend();
		rdchk(REG_SECURITY, 32'h8);
		wait_idle();
		rdchk(REG_STATUS, 32'h0);
		apb(1'b1, REG_CTRL, 32'h1);
		c1(OPC_RESUME);
		rdchk(REG_SECURITY, 32'h8);
		apb(1'b1, REG_CTRL, 32'h0);
		c1(OPC_RESUME);
		rdchk(REG_STATUS, 32'h3);
		rdchk(REG_SECURITY, 32'h0);
		wait_idle();
		rdchk(REG_STATUS, 32'h0);
		c1(OPC_WRITE_ENABLE);
		pgm(24'h00_6000);
		suspend();
		rdchk(REG_SECURITY, 32'h4);
		c1(OPC_RESUME_ALT);
		rdchk(REG_STATUS, 32'h3);
		repeat (PROGRAM_RESUME_TO_SUSPEND_GAP) @(posedge clk);
		suspend();
		rdchk(REG_SECURITY, 32'h4);
		c1(OPC_RESUME);
		rdchk(REG_STATUS, 32'h3);
		c1(OPC_RESET_ARM);
		rdchk(REG_STATUS, 32'h13);
		c1(OPC_NO_OP);
		rdchk(REG_STATUS, 32'h3);
		c1(OPC_RESET_EXEC);
		rdchk(REG_STATUS, 32'h3);
		c1(OPC_RESET_ARM);
		c1(OPC_RESET_EXEC);
		rcv_len(n_pgm);
		rdchk(REG_STATUS, 32'h0);
		c1(OPC_WRITE_ENABLE);
		apb(1'b1, REG_CTRL, 32'h1);
		c1(OPC_RESET_ARM);
		c1(OPC_WRITE_ENABLE);
		c1(OPC_RESET_EXEC);
		rdchk(REG_STATUS, 32'h2);
		c1(OPC_RESET_ARM);
		c1(OPC_RESET_EXEC);
		rcv_len(n_oth);
		chk({31'h0, n_pgm > n_oth}, 32'h1);
		rdchk(REG_CTRL, 32'h0);
		rdchk(REG_STATUS, 32'h0);
		final_report();
	end
endmodule : fsrs_core_tb
`default_nettype wire
